// >>> design/eambc_pkg.sv
// package: register layout, reset values and carriers for the eeprom and misc control block
package eambc_pkg;
   localparam int unsigned EAMBC_CLK_MHZ = 125;
   // eeprom access register field positions
   localparam int unsigned EEP_ADDR_LSB = 24;
   localparam int unsigned EEP_DATA_LSB = 16;
   localparam int unsigned EEP_ACTIVE_BIT = 7;
   localparam int unsigned EEP_READ_BIT = 6;
   // misc control two field positions
   localparam int unsigned MC2_LOCKOUT_BIT = 31;
   localparam int unsigned MC2_IMG_PF_BIT = 23;
   localparam int unsigned MC2_BB_HOLD_BIT = 22;
   localparam int unsigned MC2_RETRY_LSB = 20;
   localparam int unsigned MC2_PF_DISC_BIT = 19;
   localparam int unsigned MC2_TA_MAP_BIT = 18;
   localparam int unsigned MC2_BURST4_BIT = 17;
   localparam int unsigned MC2_SINGLE_PF_BIT = 16;
   localparam int unsigned MC2_PF_CNT2_LSB = 10;
   localparam int unsigned MC2_SLV_PW_BIT = 9;
   localparam int unsigned MC2_REG_PARK_BIT = 8;
   localparam int unsigned MC2_PARITY_BIT = 4;
   localparam int unsigned MC2_LATE_EEP_BIT = 3;
   // reset values
   localparam logic [5:0] PF_CNT2_RESET = 6'h01;
   localparam logic [5:0] PF_CNT_RESET = 6'h01;
   // retry limits
   localparam logic [1:0] RETRY_FOREVER = 2'h0;
   localparam logic [8:0] RETRY_LIM_1 = 9'h080;
   localparam logic [8:0] RETRY_LIM_2 = 9'h100;
   localparam logic [8:0] RETRY_LIM_3 = 9'h180;
   // prefetch disconnect threshold in pci clocks
   localparam logic [3:0] TRDY_WAIT_MAX = 4'h8;
   // register port select
   localparam logic PORT_PCI = 1'b0;
   localparam logic PORT_LOCAL = 1'b1;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [31:0] wdata;
   } eambc_access_t;

   typedef struct packed {
      logic pci_access_lockout;
      logic image_based_prefetch_sel;
      logic bus_busy_hold;
      logic [1:0] retry_limit;
      logic prefetch_disconnect_en;
      logic target_abort_error_map;
      logic burst_four_only;
      logic single_beat_prefetch;
      logic [5:0] second_prefetch_count;
      logic slave_posted_write_improve;
      logic register_port_parking;
      logic local_bus_parity_sense;
      logic late_eeprom_access_en;
   } eambc_misc_t;
endpackage : eambc_pkg

// >>> design/eambc_eeprom_port.sv
// eeprom access register with request handshake to the serial engine
`timescale 1ns/1ps
`default_nettype none
module eambc_eeprom_port (
   input wire logic clock,
   input wire logic rst_n,
   input wire eambc_pkg::eambc_access_t acc,
   input wire logic access_open,
   input wire logic config_loading,
   input wire logic eng_done,
   input wire logic [7:0] eng_rdata,
   output logic eng_req,
   output logic eng_read,
   output logic [7:0] eng_addr,
   output logic [7:0] eng_wdata,
   output logic [31:0] rdata,
   output logic busy
);
   logic [7:0] addr;
   logic [7:0] data;
   logic read_dir;
   logic op_pending;
   logic accept;

   assign busy = op_pending | config_loading;
   // only idle with access open accepts the write
   assign accept = acc.wr & ~busy & access_open;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         addr <= 8'h00;
         data <= 8'h00;
         read_dir <= 1'b0;
      end else if (accept) begin
         addr <= acc.wdata[eambc_pkg::EEP_ADDR_LSB +: 8];
         data <= acc.wdata[eambc_pkg::EEP_DATA_LSB +: 8];
         read_dir <= acc.wdata[eambc_pkg::EEP_READ_BIT];
      end else if (op_pending && eng_done && read_dir) begin
         data <= eng_rdata;
      end
   end

   // flag set on accept, cleared once result lands
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         op_pending <= 1'b0;
      end else if (accept) begin
         op_pending <= 1'b1;
      end else if (eng_done) begin
         op_pending <= 1'b0;
      end
   end

   assign eng_req = op_pending;
   assign eng_read = read_dir;
   assign eng_addr = addr;
   assign eng_wdata = data;

   always_comb begin
      rdata = 32'h0000_0000;
      if (access_open) begin
         rdata[eambc_pkg::EEP_ADDR_LSB +: 8] = addr;
         rdata[eambc_pkg::EEP_DATA_LSB +: 8] = data;
         rdata[eambc_pkg::EEP_ACTIVE_BIT] = busy;
         rdata[eambc_pkg::EEP_READ_BIT] = read_dir;
      end
   end

   property p_accept_sets;
      @(posedge clock) disable iff (!rst_n) accept |=> op_pending;
   endproperty
   a_accept_sets: assert property (p_accept_sets) else $error("busy not set");

   property p_busy_blocks;
      @(posedge clock) disable iff (!rst_n)
         (acc.wr && busy) |=> (addr == $past(addr));
   endproperty
   a_busy_blocks: assert property (p_busy_blocks) else $error("write while busy");

   sequence s_op_done;
      op_pending && eng_done;
   endsequence

   property p_done_clears;
      @(posedge clock) disable iff (!rst_n) s_op_done |=> !op_pending;
   endproperty
   a_done_clears: assert property (p_done_clears) else $error("busy not cleared");
endmodule : eambc_eeprom_port
`default_nettype wire

// >>> design/eambc_top.sv
// eeprom access and misc control two registers with their steering effects
// Operation
// - address bits 31-24, data bits 23-16
// - active flag high while loading or busy
// - accesses take effect only when not active
// - writes always complete normally on bus
// - direction bit zero write, one read
// - no eeprom strap makes register zero
// - lockout bit makes every pci access retry
// - image prefetch selects per image counts
// - bus busy hold across back-to-back cycles
// - retry limit none, 128, 256, 384
// - disconnect after eight trdy wait clocks
// - target abort mapped to bus error
// - both bits zero map both aborts
// - burst four forces four data phases
// - single beat prefetch in burst mode
// - second count times four, reset one
// - improved posted write dequeue select
// - register port parks or defaults pci
// - parity even at zero, odd at one
// - late enable reopens eeprom access
// - lockout loads strap at pci reset release, reset clears it
`timescale 1ns/1ps
`default_nettype none
module eambc_top (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic pci_rst_n,
   input wire logic serial_data_strap,
   input wire logic enable_id_strap,
   input wire logic lockout_strap,
   input wire logic config_loading,
   input wire logic eep_sel_is_pci,
   input wire eambc_pkg::eambc_access_t eep_acc,
   input wire eambc_pkg::eambc_access_t mc2_acc,
   input wire logic access_from_local,
   input wire logic reg_block_access,
   output logic [31:0] eep_rdata,
   output logic [31:0] mc2_rdata,
   output logic write_ack,
   input wire logic eng_done,
   input wire logic [7:0] eng_rdata,
   output logic eng_req,
   output logic eng_read,
   output logic [7:0] eng_addr,
   output logic [7:0] eng_wdata,
   output logic eeprom_active_flag,
   input wire logic pci_access_req,
   output logic pci_retry,
   input wire logic [1:0] target_image,
   input wire logic [5:0] primary_prefetch_count,
   output logic [7:0] prefetch_bytes,
   input wire logic target_cycle_end,
   input wire logic target_next_pending,
   output logic bus_busy_release,
   input wire logic master_retry,
   input wire logic master_start,
   output logic retry_exhausted,
   input wire logic trdy_wait,
   output logic target_disconnect,
   input wire logic master_abort_map_disable,
   input wire logic got_master_abort,
   input wire logic got_target_abort,
   output logic local_bus_error,
   input wire logic [1:0] write_beats_avail,
   output logic [2:0] burst_len,
   input wire logic burst_master_mode,
   output logic prefetch_single,
   output logic slave_posted_write_improve,
   output logic register_port_sel,
   input wire logic [31:0] par_data,
   output logic par_bit
);
   eambc_pkg::eambc_misc_t misc;
   logic eeprom_present;
   logic pci_rst_q;
   logic access_open;
   logic park_sel;
   logic [8:0] retry_count;
   logic [8:0] retry_max;
   logic [3:0] trdy_count;

   function automatic logic [8:0] eambc_retry_max(input logic [1:0] code);
      case (code)
         2'h1: eambc_retry_max = eambc_pkg::RETRY_LIM_1;
         2'h2: eambc_retry_max = eambc_pkg::RETRY_LIM_2;
         2'h3: eambc_retry_max = eambc_pkg::RETRY_LIM_3;
         default: eambc_retry_max = 9'h000;
      endcase
   endfunction : eambc_retry_max

   // strap capture while pci reset is low, held after release
   always_ff @(posedge clock) begin
      pci_rst_q <= pci_rst_n;
      if (!pci_rst_n) begin
         eeprom_present <= serial_data_strap | enable_id_strap;
      end
   end

   assign access_open = eeprom_present | misc.late_eeprom_access_en;

   eambc_eeprom_port u_eep (
      .clock(clock),
      .rst_n(rst_n & pci_rst_n),
      .acc(eep_acc),
      .access_open(access_open),
      .config_loading(config_loading),
      .eng_done(eng_done),
      .eng_rdata(eng_rdata),
      .eng_req(eng_req),
      .eng_read(eng_read),
      .eng_addr(eng_addr),
      .eng_wdata(eng_wdata),
      .rdata(eep_rdata),
      .busy(eeprom_active_flag)
   );

   // writes always acknowledged, effective or not
   assign write_ack = eep_acc.wr | mc2_acc.wr;

   // misc control two register
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         misc <= '0;
         misc.second_prefetch_count <= eambc_pkg::PF_CNT2_RESET;
         misc.pci_access_lockout <= 1'b0;
      end else if (!pci_rst_q && pci_rst_n) begin
         misc.pci_access_lockout <= lockout_strap;
      end else if (mc2_acc.wr) begin
         misc.pci_access_lockout <= mc2_acc.wdata[eambc_pkg::MC2_LOCKOUT_BIT];
         misc.image_based_prefetch_sel <= mc2_acc.wdata[eambc_pkg::MC2_IMG_PF_BIT];
         misc.bus_busy_hold <= mc2_acc.wdata[eambc_pkg::MC2_BB_HOLD_BIT];
         misc.retry_limit <= mc2_acc.wdata[eambc_pkg::MC2_RETRY_LSB +: 2];
         misc.prefetch_disconnect_en <= mc2_acc.wdata[eambc_pkg::MC2_PF_DISC_BIT];
         misc.target_abort_error_map <= mc2_acc.wdata[eambc_pkg::MC2_TA_MAP_BIT];
         misc.burst_four_only <= mc2_acc.wdata[eambc_pkg::MC2_BURST4_BIT];
         misc.single_beat_prefetch <= mc2_acc.wdata[eambc_pkg::MC2_SINGLE_PF_BIT];
         misc.second_prefetch_count <= mc2_acc.wdata[eambc_pkg::MC2_PF_CNT2_LSB +: 6];
         misc.slave_posted_write_improve <= mc2_acc.wdata[eambc_pkg::MC2_SLV_PW_BIT];
         misc.register_port_parking <= mc2_acc.wdata[eambc_pkg::MC2_REG_PARK_BIT];
         misc.local_bus_parity_sense <= mc2_acc.wdata[eambc_pkg::MC2_PARITY_BIT];
         misc.late_eeprom_access_en <= mc2_acc.wdata[eambc_pkg::MC2_LATE_EEP_BIT];
      end
   end

   always_comb begin
      mc2_rdata = 32'h0000_0000;
      mc2_rdata[eambc_pkg::MC2_LOCKOUT_BIT] = misc.pci_access_lockout;
      mc2_rdata[eambc_pkg::MC2_IMG_PF_BIT] = misc.image_based_prefetch_sel;
      mc2_rdata[eambc_pkg::MC2_BB_HOLD_BIT] = misc.bus_busy_hold;
      mc2_rdata[eambc_pkg::MC2_RETRY_LSB +: 2] = misc.retry_limit;
      mc2_rdata[eambc_pkg::MC2_PF_DISC_BIT] = misc.prefetch_disconnect_en;
      mc2_rdata[eambc_pkg::MC2_TA_MAP_BIT] = misc.target_abort_error_map;
      mc2_rdata[eambc_pkg::MC2_BURST4_BIT] = misc.burst_four_only;
      mc2_rdata[eambc_pkg::MC2_SINGLE_PF_BIT] = misc.single_beat_prefetch;
      mc2_rdata[eambc_pkg::MC2_PF_CNT2_LSB +: 6] = misc.second_prefetch_count;
      mc2_rdata[eambc_pkg::MC2_SLV_PW_BIT] = misc.slave_posted_write_improve;
      mc2_rdata[eambc_pkg::MC2_REG_PARK_BIT] = misc.register_port_parking;
      mc2_rdata[eambc_pkg::MC2_PARITY_BIT] = misc.local_bus_parity_sense;
      mc2_rdata[eambc_pkg::MC2_LATE_EEP_BIT] = misc.late_eeprom_access_en;
   end

   assign pci_retry = pci_access_req & misc.pci_access_lockout;

   // prefetch size in bytes
   always_comb begin
      if (misc.image_based_prefetch_sel && target_image == 2'h1) begin
         prefetch_bytes = {misc.second_prefetch_count, 2'h0};
      end else begin
         prefetch_bytes = {primary_prefetch_count, 2'h0};
      end
   end

   assign bus_busy_release = target_cycle_end & ~(misc.bus_busy_hold & target_next_pending);

   // master retry counter
   assign retry_max = eambc_retry_max(misc.retry_limit);
   always_ff @(posedge clock) begin
      if (!rst_n || master_start) begin
         retry_count <= 9'h000;
      end else if (master_retry && !retry_exhausted) begin
         retry_count <= retry_count + 9'h001;
      end
   end
   assign retry_exhausted = (misc.retry_limit != eambc_pkg::RETRY_FOREVER)
                            && (retry_count >= retry_max);

   // trdy wait counter for disconnect
   always_ff @(posedge clock) begin
      if (!rst_n || !trdy_wait) begin
         trdy_count <= 4'h0;
      end else if (trdy_count != eambc_pkg::TRDY_WAIT_MAX) begin
         trdy_count <= trdy_count + 4'h1;
      end
   end
   assign target_disconnect = misc.prefetch_disconnect_en & trdy_wait
                              & (trdy_count == eambc_pkg::TRDY_WAIT_MAX);

   // abort to bus error mapping
   always_comb begin
      if (!master_abort_map_disable) begin
         local_bus_error = got_master_abort | got_target_abort;
      end else begin
         local_bus_error = got_target_abort & misc.target_abort_error_map;
      end
   end

   // burst shape for target channel writes
   always_comb begin
      if (misc.burst_four_only || write_beats_avail == 2'h0) begin
         burst_len = 3'h4;
      end else begin
         burst_len = {1'b0, write_beats_avail};
      end
   end

   assign prefetch_single = burst_master_mode & misc.single_beat_prefetch;
   assign slave_posted_write_improve = misc.slave_posted_write_improve;

   // register port parking
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         park_sel <= eambc_pkg::PORT_PCI;
      end else if (reg_block_access) begin
         park_sel <= access_from_local;
      end
   end
   assign register_port_sel = misc.register_port_parking ? park_sel : eambc_pkg::PORT_PCI;

   assign par_bit = (^par_data) ^ misc.local_bus_parity_sense;

   property p_lockout_retry;
      @(posedge clock) disable iff (!rst_n)
         (misc.pci_access_lockout && pci_access_req) |-> pci_retry;
   endproperty
   a_lockout_retry: assert property (p_lockout_retry) else $error("no retry");

   sequence s_wait_eight;
      (misc.prefetch_disconnect_en && trdy_wait) [*8];
   endsequence

   property p_disc_eight;
      @(posedge clock) disable iff (!rst_n)
         s_wait_eight |=> ((misc.prefetch_disconnect_en && trdy_wait) |-> target_disconnect);
   endproperty
   a_disc_eight: assert property (p_disc_eight) else $error("no disconnect");

   property p_bus_err;
      @(posedge clock) disable iff (!rst_n)
         (!master_abort_map_disable && got_master_abort) |-> local_bus_error;
   endproperty
   a_bus_err: assert property (p_bus_err) else $error("abort not mapped");

   property p_no_retry;
      @(posedge clock) disable iff (!rst_n)
         !misc.pci_access_lockout |-> !pci_retry;
   endproperty
   a_no_retry: assert property (p_no_retry) else $error("retry without lockout");

   property p_write_ack;
      @(posedge clock) disable iff (!rst_n)
         (eep_acc.wr || mc2_acc.wr) |-> write_ack;
   endproperty
   a_write_ack: assert property (p_write_ack) else $error("write not acked");

   property p_no_eep_zero;
      @(posedge clock) disable iff (!rst_n)
         !access_open |-> (eep_rdata == 32'h0000_0000);
   endproperty
   a_no_eep_zero: assert property (p_no_eep_zero) else $error("closed reg not zero");

   property p_late_open;
      @(posedge clock) disable iff (!rst_n)
         misc.late_eeprom_access_en |-> access_open;
   endproperty
   a_late_open: assert property (p_late_open) else $error("late enable ignored");

   property p_bb_hold;
      @(posedge clock) disable iff (!rst_n)
         (misc.bus_busy_hold && target_cycle_end && target_next_pending) |-> !bus_busy_release;
   endproperty
   a_bb_hold: assert property (p_bb_hold) else $error("bus busy dropped");

   property p_bb_free;
      @(posedge clock) disable iff (!rst_n)
         (!misc.bus_busy_hold && target_cycle_end) |-> bus_busy_release;
   endproperty
   a_bb_free: assert property (p_bb_free) else $error("bus busy kept");

   property p_retry_forever;
      @(posedge clock) disable iff (!rst_n)
         (misc.retry_limit == eambc_pkg::RETRY_FOREVER) |-> !retry_exhausted;
   endproperty
   a_retry_forever: assert property (p_retry_forever) else $error("unlimited retry cut");

   property p_retry_below;
      @(posedge clock) disable iff (!rst_n)
         (misc.retry_limit == 2'h1 && retry_count < eambc_pkg::RETRY_LIM_1) |-> !retry_exhausted;
   endproperty
   a_retry_below: assert property (p_retry_below) else $error("retry cut early");

   property p_no_disc;
      @(posedge clock) disable iff (!rst_n)
         !misc.prefetch_disconnect_en |-> !target_disconnect;
   endproperty
   a_no_disc: assert property (p_no_disc) else $error("disconnect while off");

   property p_ta_normal;
      @(posedge clock) disable iff (!rst_n)
         (master_abort_map_disable && !misc.target_abort_error_map) |-> !local_bus_error;
   endproperty
   a_ta_normal: assert property (p_ta_normal) else $error("abort not normal");

   property p_burst_four;
      @(posedge clock) disable iff (!rst_n)
         misc.burst_four_only |-> (burst_len == 3'h4);
   endproperty
   a_burst_four: assert property (p_burst_four) else $error("short burst");

   property p_single_pf;
      @(posedge clock) disable iff (!rst_n)
         (burst_master_mode && misc.single_beat_prefetch) |-> prefetch_single;
   endproperty
   a_single_pf: assert property (p_single_pf) else $error("no single prefetch");

   property p_park_pci;
      @(posedge clock) disable iff (!rst_n)
         !misc.register_port_parking |-> (register_port_sel == eambc_pkg::PORT_PCI);
   endproperty
   a_park_pci: assert property (p_park_pci) else $error("port not on pci");

   property p_parity;
      @(posedge clock) disable iff (!rst_n)
         (^{par_data, par_bit}) == misc.local_bus_parity_sense;
   endproperty
   a_parity: assert property (p_parity) else $error("parity sense wrong");

   sequence s_pci_release;
      !pci_rst_n ##1 pci_rst_n;
   endsequence

   property p_strap_load;
      @(posedge clock) disable iff (!rst_n)
         s_pci_release |=> (misc.pci_access_lockout == $past(lockout_strap));
   endproperty
   a_strap_load: assert property (p_strap_load) else $error("strap not loaded");
endmodule : eambc_top
`default_nettype wire

// >>> testbench/eambc_eeprom_model.sv
// serial eeprom engine model answering the block's byte requests
`timescale 1ns/1ps
`default_nettype none
module eambc_eeprom_model (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic eng_req,
   input wire logic eng_read,
   input wire logic [7:0] eng_addr,
   input wire logic [7:0] eng_wdata,
   output logic eng_done,
   output logic [7:0] eng_rdata
);
   logic [7:0] mem [256];
   logic [3:0] cnt;
   logic [7:0] last;
   // one done pulse per request, after a short or a long wait
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cnt <= 4'h0;
         eng_done <= 1'b0;
         last <= 8'h00;
      end else if (eng_done) begin
         eng_done <= 1'b0;
         cnt <= 4'h0;
      end else if (eng_req) begin
         if (cnt == (slow ? 4'hC : 4'h2)) begin
            eng_done <= 1'b1;
            if (eng_read) last <= mem[eng_addr];
            else mem[eng_addr] <= eng_wdata;
         end else begin
            cnt <= cnt + 4'h1;
         end
      end
   end
   // data only valid with done, inverted otherwise
   assign eng_rdata = eng_done ? last : ~last;
endmodule : eambc_eeprom_model
`default_nettype wire

// >>> testbench/tb.sv
// testbench for the eeprom and misc control registers
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clock, rst_n, pci_rst_n, sd_strap, id_strap, lo_strap, loading, slow;
   logic from_local, blk_acc, pci_req, t_end, t_next, m_retry, m_start, trdy_wait;
   logic ma_dis, got_ma, got_ta, bm_mode;
   logic [1:0] timg, beats;
   logic [5:0] pcnt;
   logic [31:0] par_data, eep_rdata, mc2_rdata;
   eambc_pkg::eambc_access_t eep_acc, mc2_acc;
   logic write_ack, eng_done, eng_req, eng_read, flag, pci_retry, bb_rel, r_exh, disc;
   logic bus_err, pf_single, spw, port_sel, par_bit;
   logic [7:0] eng_rdata, eng_addr, eng_wdata, pf_bytes;
   logic [2:0] burst_len;
   int bad_count, check_count;
   eambc_top i_eambc_top (.clock(clock), .rst_n(rst_n), .pci_rst_n(pci_rst_n),
      .serial_data_strap(sd_strap), .enable_id_strap(id_strap), .lockout_strap(lo_strap),
      .config_loading(loading), .eep_sel_is_pci(1'b1), .eep_acc(eep_acc), .mc2_acc(mc2_acc),
      .access_from_local(from_local), .reg_block_access(blk_acc), .eep_rdata(eep_rdata),
      .mc2_rdata(mc2_rdata), .write_ack(write_ack), .eng_done(eng_done),
      .eng_rdata(eng_rdata), .eng_req(eng_req), .eng_read(eng_read), .eng_addr(eng_addr),
      .eng_wdata(eng_wdata), .eeprom_active_flag(flag), .pci_access_req(pci_req),
      .pci_retry(pci_retry), .target_image(timg), .primary_prefetch_count(pcnt),
      .prefetch_bytes(pf_bytes), .target_cycle_end(t_end), .target_next_pending(t_next),
      .bus_busy_release(bb_rel), .master_retry(m_retry), .master_start(m_start),
      .retry_exhausted(r_exh), .trdy_wait(trdy_wait), .target_disconnect(disc),
      .master_abort_map_disable(ma_dis), .got_master_abort(got_ma),
      .got_target_abort(got_ta), .local_bus_error(bus_err), .write_beats_avail(beats),
      .burst_len(burst_len), .burst_master_mode(bm_mode), .prefetch_single(pf_single),
      .slave_posted_write_improve(spw), .register_port_sel(port_sel),
      .par_data(par_data), .par_bit(par_bit));
   eambc_eeprom_model i_eambc_eeprom_model (.clock(clock), .rst_n(rst_n), .slow(slow),
      .eng_req(eng_req), .eng_read(eng_read), .eng_addr(eng_addr),
      .eng_wdata(eng_wdata), .eng_done(eng_done), .eng_rdata(eng_rdata));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic results();
      if (bad_count == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : results
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : cyc
   task automatic wr(input logic sel, input logic [31:0] d);
      @(posedge clock);
      if (sel) mc2_acc <= {2'b01, d};
      else eep_acc <= {2'b01, d};
      #1 chk(32'(write_ack), 32'h1);
      @(posedge clock);
      mc2_acc <= '0;
      eep_acc <= '0;
      #1;
   endtask : wr
   task automatic wait_idle();
      int n;
      n = 0;
      while (flag !== 1'b0 && n < 40) begin
         cyc(1);
         n++;
      end
      chk(32'(flag), 32'h0);
   endtask : wait_idle
   task automatic t_reset_values();
      chk(mc2_rdata, 32'h80000400);
      chk({eep_rdata, 31'h0, flag}, 64'h0);
      pci_req <= 1'b1;
      cyc(1);
      chk(32'(pci_retry), 32'h1);
   endtask : t_reset_values
   task automatic t_eeprom();
      wr(1'b0, 32'h5AC30000);
      chk({eng_req, eng_read, eng_addr, eng_wdata, flag}, 19'h4B587);
      wait_idle();
      slow <= 1'b1;
      wr(1'b0, 32'h5A000040);
      chk(32'(flag), 32'h1);
      wr(1'b0, 32'h11220000);
      chk({eng_read, eng_addr}, 9'h15A);
      wait_idle();
      chk(eep_rdata, 32'h5AC30040);
   endtask : t_eeprom
   task automatic t_loading();
      loading <= 1'b1;
      cyc(1);
      chk(32'(flag), 32'h1);
      wr(1'b0, 32'h77000000);
      chk({eng_req, eng_addr}, 9'h05A);
      loading <= 1'b0;
      cyc(1);
      chk(32'(flag), 32'h0);
   endtask : t_loading
   task automatic t_bus();
      wr(1'b1, 32'h00100000);
      {t_end, t_next, beats} <= {2'b11, 2'h3};
      cyc(1);
      chk({bb_rel, burst_len}, 4'hB);
      m_start <= 1'b1;
      cyc(1);
      {m_start, m_retry} <= 2'b01;
      cyc(127);
      chk(32'(r_exh), 32'h0);
      cyc(1);
      chk(32'(r_exh), 32'h1);
      wr(1'b1, 32'h00400000);
      chk({bb_rel, r_exh}, 2'b00);
      {t_next, m_retry, beats} <= 4'h0;
      cyc(1);
      chk({bb_rel, burst_len}, 4'hC);
   endtask : t_bus
   task automatic t_misc();
      wr(1'b1, 32'h00FF3310);
      chk(mc2_rdata, 32'h00FF3310);
      {timg, pcnt, beats, bm_mode, par_data, from_local, blk_acc} <= {2'h1, 6'h05, 2'h2, 1'b1,
         32'h1, 2'b11};
      {got_ta, ma_dis, trdy_wait} <= 3'b111;
      cyc(1);
      {from_local, blk_acc} <= 2'b00;
      chk(32'(pci_retry), 32'h0);
      chk(32'(pf_bytes), 32'h30);
      chk({burst_len, pf_single, spw, par_bit, bus_err}, 7'h4D);
      timg <= 2'h0;
      cyc(1);
      chk({pf_bytes, port_sel}, {8'h14, eambc_pkg::PORT_LOCAL});
      cyc(9);
      chk(32'(disc), 32'h1);
      wr(1'b1, 32'h0);
      {from_local, blk_acc, got_ta, got_ma, ma_dis} <= 5'b11110;
      cyc(1);
      chk({bus_err, par_bit}, 2'b11);
      {from_local, blk_acc, ma_dis, got_ma} <= 4'b0010;
      cyc(10);
      chk({bus_err, disc, port_sel}, {2'b00, eambc_pkg::PORT_PCI});
      trdy_wait <= 1'b0;
   endtask : t_misc
   task automatic t_no_eeprom();
      {sd_strap, id_strap, lo_strap, slow, pci_rst_n} <= 5'b00100;
      cyc(2);
      pci_rst_n <= 1'b1;
      cyc(2);
      chk(32'(pci_retry), 32'h1);
      wr(1'b0, 32'h33440000);
      chk({eep_rdata, 31'h0, flag}, 64'h0);
      wr(1'b1, 32'h00000008);
      wr(1'b0, 32'h33440000);
      chk({eng_req, eng_addr, eng_wdata, flag}, 18'h26689);
      wait_idle();
   endtask : t_no_eeprom
   initial begin
      bad_count = 0;
      check_count = 0;
      {rst_n, pci_rst_n, loading, slow, from_local, blk_acc, pci_req, t_end, t_next} = '0;
      {m_retry, m_start, trdy_wait, ma_dis, got_ma, got_ta, bm_mode, timg, beats, pcnt} = '0;
      {sd_strap, id_strap, lo_strap, par_data} = {3'b111, 32'h0};
      eep_acc = '0;
      mc2_acc = '0;
      cyc(6);
      rst_n <= 1'b1;
      pci_rst_n <= 1'b1;
      cyc(2);
      t_reset_values();
      t_eeprom();
      t_loading();
      t_misc();
      t_bus();
      t_no_eeprom();
      results();
   end
   initial begin
      repeat (20000) @(posedge clock);
      bad_count++;
      results();
   end
endmodule : tb
`default_nettype wire
